// >>> mscb_defines.vh
// mscb_defines.vh: offsets, field positions and reset values of the bank
// assumes: included by the bank module, byte addresses on a 32-bit apb bus
`ifndef MSCB_DEFINES_VH
`define MSCB_DEFINES_VH

// register indices, byte address is four times the index
`define MSCB_IDX_PWM_A_INV     8'h60
`define MSCB_IDX_PWM_B_INV     8'h61
`define MSCB_IDX_XTAL_CHOICE   8'h63
`define MSCB_IDX_LVD_DELAY     8'h65
`define MSCB_IDX_BROWNOUT      8'h66
`define MSCB_IDX_SERIAL_EXT    8'h67
`define MSCB_IDX_SPI_PINS      8'h68
`define MSCB_IDX_SPI_RXCLK     8'h69
`define MSCB_IDX_JUMP_KEY      8'h6A
`define MSCB_IDX_OFS_LOW       8'h6B
`define MSCB_IDX_OFS_HIGH      8'h6C

// writable field masks (reserved bits read zero)
`define MSCB_MASK_PWM          8'h1F
`define MSCB_MASK_BIT0         8'h01
`define MSCB_MASK_LVD          8'h03
`define MSCB_MASK_BROWNOUT     8'h0F
`define MSCB_MASK_SPI_PINS     8'h03

// brownout field positions
`define MSCB_BOR_DELAY_BIT     3
`define MSCB_BOR_VTH_MSB       2

// reset values
`define MSCB_RST_BYTE          8'h00
`define MSCB_RST_OFFSET        16'h0000

// spi pin group codes
`define MSCB_SPI_PORT_C        2'h1
`define MSCB_SPI_PORT_E        2'h2

// brownout threshold level codes driven out
`define MSCB_BOR_2V3           3'h0
`define MSCB_BOR_2V8           3'h1
`define MSCB_BOR_3V3           3'h2
`define MSCB_BOR_3V7           3'h3
`define MSCB_BOR_4V2           3'h4

// key sequences, five bytes each
`define MSCB_KEY_MAIN          40'hFF008855AA
`define MSCB_KEY_BOOT          40'h37C8429A65
`define MSCB_KEY_LEN           3'h5

`endif

// >>> mscb_config_bank.v
// mscb_config_bank.v: miscellaneous configuration register bank on apb
// assumes: one clock, synchronous reset, apb master holds its request
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "mscb_defines.vh"

// Contract
// - group a bits invert channels a..e
// - group b bits invert channels a..e
// - crystal bit set 4MHz, clear 32768Hz
// - two-bit low voltage delay, four settings
// - brownout bit 3 chooses delay one/two
// - threshold code maps to five trip levels
// - one bit widens uart divider to 12
// - spi pins: 01 C, 10 E, else G
// - master rx clock: internal or pad
// - main key sequence jumps to main space
// - boot key sequence jumps to boot space
// - key register reads last written byte
// - read-only 16-bit code offset, resets zero
module mscb_config_bank (
	input  wire        clk_sys,          // system clock
	input  wire        rst_b,            // sync reset, active low
	input  wire        psel,             // apb select
	input  wire        penable,          // apb access phase
	input  wire        pwrite,           // apb direction
	input  wire [11:0] paddr,            // apb byte address
	input  wire [31:0] pwdata,           // apb write data
	output reg  [31:0] prdata,           // apb read data
	output reg         pready,           // apb ready
	output reg         pslverr,          // apb error
	input  wire [15:0] code_offset_in,   // offset from flash boot logic
	output reg  [4:0]  pwm_a_invert,     // group a polarity
	output reg  [4:0]  pwm_b_invert,     // group b polarity
	output reg         xtal_fast,        // 1: 4MHz, 0: 32768Hz
	output reg  [1:0]  low_voltage_detector_delay, // delay setting
	output reg         brownout_delay2,  // 1: second delay
	output reg  [2:0]  brownout_level,   // 0..4 = 2.3..4.2 V
	output reg         serial_rate_wide, // 1: 12-bit divider
	output reg  [2:0]  spi_route,        // onehot: {G, E, C}
	output reg         spi_rx_internal,  // 1: internal master clock
	output reg         jump_main,        // pulse: enter main space
	output reg         jump_boot         // pulse: enter boot space
);

////////////////////////////////////////////////////////////////////////////
	wire [7:0]  pwm_a_reg;      // settings bytes, reserved bits zero
	wire [7:0]  pwm_b_reg;
	wire [7:0]  xtal_reg;
	wire [7:0]  lvd_reg;
	wire [7:0]  bor_reg;
	wire [7:0]  uart_reg;
	wire [7:0]  spi_pins_reg;
	wire [7:0]  spi_rxclk_reg;
	reg  [7:0]  key_reg;
	reg  [15:0] offset_reg;
	reg  [7:0]  rd_byte;
	reg         rd_hit;
	reg  [2:0]  bor_level_next;
	reg  [2:0]  spi_route_next;

	wire        access;
	wire        wr_en;
	wire        idx_ok;
	wire [9:0]  idx;
	wire [7:0]  wb;
	wire        key_wr;
	wire        main_done;      // main key completed by this write
	wire        boot_done;      // boot key completed by this write

	// apb decode: accept in the first access cycle, answer in the next
	assign access = psel & penable & ~pready;
	assign idx    = paddr[11:2];
	assign idx_ok = (paddr[1:0] == 2'h0) && (idx[9:8] == 2'h0);
	assign wr_en  = access & pwrite & idx_ok;
	assign wb     = pwdata[7:0];
	assign key_wr = wr_en && (idx[7:0] == `MSCB_IDX_JUMP_KEY);

////////////////////////////////////////////////////////////////////////////
	// read multiplexer, reserved bits stored as zero
	always @* begin
		rd_hit = 1'b1;
		case (idx[7:0])
		`MSCB_IDX_PWM_A_INV:   rd_byte = pwm_a_reg;
		`MSCB_IDX_PWM_B_INV:   rd_byte = pwm_b_reg;
		`MSCB_IDX_XTAL_CHOICE: rd_byte = xtal_reg;
		`MSCB_IDX_LVD_DELAY:   rd_byte = lvd_reg;
		`MSCB_IDX_BROWNOUT:    rd_byte = bor_reg;
		`MSCB_IDX_SERIAL_EXT:  rd_byte = uart_reg;
		`MSCB_IDX_SPI_PINS:    rd_byte = spi_pins_reg;
		`MSCB_IDX_SPI_RXCLK:   rd_byte = spi_rxclk_reg;
		`MSCB_IDX_JUMP_KEY:    rd_byte = key_reg;
		`MSCB_IDX_OFS_LOW:     rd_byte = offset_reg[7:0];
		`MSCB_IDX_OFS_HIGH:    rd_byte = offset_reg[15:8];
		default: begin
			rd_byte = `MSCB_RST_BYTE;
			rd_hit  = 1'b0;
		end
		endcase
		if (!idx_ok) begin
			rd_hit = 1'b0;
		end
	end

////////////////////////////////////////////////////////////////////////////
	// one matcher per key, both follow every key register write
	mscb_key_match #(
		.KEY     (`MSCB_KEY_MAIN)
	) u_mscb_key_match_main (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.key_wr  (key_wr),
		.wb      (wb),
		.done    (main_done)
	);

	mscb_key_match #(
		.KEY     (`MSCB_KEY_BOOT)
	) u_mscb_key_match_boot (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.key_wr  (key_wr),
		.wb      (wb),
		.done    (boot_done)
	);

////////////////////////////////////////////////////////////////////////////
	// decoded settings for the consumer blocks
	always @* begin
		case (bor_reg[`MSCB_BOR_VTH_MSB:0])
		3'h0, 3'h1: bor_level_next = `MSCB_BOR_2V3;
		3'h2:       bor_level_next = `MSCB_BOR_2V8;
		3'h3:       bor_level_next = `MSCB_BOR_3V3;
		3'h4:       bor_level_next = `MSCB_BOR_3V7;
		default:    bor_level_next = `MSCB_BOR_4V2;
		endcase
		case (spi_pins_reg[1:0])
		`MSCB_SPI_PORT_C: spi_route_next = 3'h1;
		`MSCB_SPI_PORT_E: spi_route_next = 3'h2;
		default:          spi_route_next = 3'h4;
		endcase
	end

////////////////////////////////////////////////////////////////////////////
	// settings bytes, each keeps only its writable bits
	mscb_cfg_byte #(
		.IDX     (`MSCB_IDX_PWM_A_INV),
		.MASK    (`MSCB_MASK_PWM)
	) u_mscb_cfg_byte_pwm_a (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.wr_en   (wr_en),
		.idx     (idx[7:0]),
		.wb      (wb),
		.q       (pwm_a_reg)
	);

	mscb_cfg_byte #(
		.IDX     (`MSCB_IDX_PWM_B_INV),
		.MASK    (`MSCB_MASK_PWM)
	) u_mscb_cfg_byte_pwm_b (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.wr_en   (wr_en),
		.idx     (idx[7:0]),
		.wb      (wb),
		.q       (pwm_b_reg)
	);

	mscb_cfg_byte #(
		.IDX     (`MSCB_IDX_XTAL_CHOICE),
		.MASK    (`MSCB_MASK_BIT0)
	) u_mscb_cfg_byte_xtal (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.wr_en   (wr_en),
		.idx     (idx[7:0]),
		.wb      (wb),
		.q       (xtal_reg)
	);

	mscb_cfg_byte #(
		.IDX     (`MSCB_IDX_LVD_DELAY),
		.MASK    (`MSCB_MASK_LVD)
	) u_mscb_cfg_byte_lvd (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.wr_en   (wr_en),
		.idx     (idx[7:0]),
		.wb      (wb),
		.q       (lvd_reg)
	);

	mscb_cfg_byte #(
		.IDX     (`MSCB_IDX_BROWNOUT),
		.MASK    (`MSCB_MASK_BROWNOUT)
	) u_mscb_cfg_byte_bor (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.wr_en   (wr_en),
		.idx     (idx[7:0]),
		.wb      (wb),
		.q       (bor_reg)
	);

	mscb_cfg_byte #(
		.IDX     (`MSCB_IDX_SERIAL_EXT),
		.MASK    (`MSCB_MASK_BIT0)
	) u_mscb_cfg_byte_uart (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.wr_en   (wr_en),
		.idx     (idx[7:0]),
		.wb      (wb),
		.q       (uart_reg)
	);

	mscb_cfg_byte #(
		.IDX     (`MSCB_IDX_SPI_PINS),
		.MASK    (`MSCB_MASK_SPI_PINS)
	) u_mscb_cfg_byte_spi_pins (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.wr_en   (wr_en),
		.idx     (idx[7:0]),
		.wb      (wb),
		.q       (spi_pins_reg)
	);

	mscb_cfg_byte #(
		.IDX     (`MSCB_IDX_SPI_RXCLK),
		.MASK    (`MSCB_MASK_BIT0)
	) u_mscb_cfg_byte_spi_rxclk (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.wr_en   (wr_en),
		.idx     (idx[7:0]),
		.wb      (wb),
		.q       (spi_rxclk_reg)
	);

	// key byte, offset copy and apb answer
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			key_reg    <= `MSCB_RST_BYTE;
			offset_reg <= `MSCB_RST_OFFSET;
			prdata     <= 32'h00000000;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			jump_main  <= 1'b0;
			jump_boot  <= 1'b0;
		end else begin
			pready     <= access;
			pslverr    <= access & ~rd_hit;
			prdata     <= (access & ~pwrite) ? {24'h000000, rd_byte}
				: 32'h00000000;
			offset_reg <= code_offset_in;
			jump_main  <= main_done;
			jump_boot  <= boot_done;
			if (key_wr) begin
				key_reg <= wb;
			end
		end
	end

	// settings driven from flops, one cycle behind the registers
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			pwm_a_invert               <= 5'h00;
			pwm_b_invert               <= 5'h00;
			xtal_fast                  <= 1'b0;
			low_voltage_detector_delay <= 2'h0;
			brownout_delay2            <= 1'b0;
			brownout_level             <= `MSCB_BOR_2V3;
			serial_rate_wide           <= 1'b0;
			spi_route                  <= 3'h4;
			spi_rx_internal            <= 1'b0;
		end else begin
			pwm_a_invert               <= pwm_a_reg[4:0];
			pwm_b_invert               <= pwm_b_reg[4:0];
			xtal_fast                  <= xtal_reg[0];
			low_voltage_detector_delay <= lvd_reg[1:0];
			brownout_delay2 <= bor_reg[`MSCB_BOR_DELAY_BIT];
			brownout_level             <= bor_level_next;
			serial_rate_wide           <= uart_reg[0];
			spi_route                  <= spi_route_next;
			spi_rx_internal            <= spi_rxclk_reg[0];
		end
	end

endmodule

////////////////////////////////////////////////////////////////////////////
// one masked settings byte: reserved bits stay zero whatever is written
module mscb_cfg_byte #(
	parameter [7:0] IDX  = 8'h00, // register index it answers to
	parameter [7:0] MASK = 8'hFF  // writable bits
) (
	input  wire       clk_sys,    // system clock
	input  wire       rst_b,      // sync reset, active low
	input  wire       wr_en,      // accepted apb write
	input  wire [7:0] idx,        // register index of the write
	input  wire [7:0] wb,         // byte written
	output reg  [7:0] q           // stored value
);

	// a write takes only the writable bits
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			q <= `MSCB_RST_BYTE;
		end else if (wr_en && (idx == IDX)) begin
			q <= wb & MASK;
		end
	end

endmodule

////////////////////////////////////////////////////////////////////////////
// key matcher: follows one five-byte sequence on the key register
module mscb_key_match #(
	parameter [39:0] KEY = `MSCB_KEY_MAIN // first byte in the top bits
) (
	input  wire       clk_sys,    // system clock
	input  wire       rst_b,      // sync reset, active low
	input  wire       key_wr,     // accepted write to the key register
	input  wire [7:0] wb,         // byte written
	output wire       done        // this write ends the sequence
);

	reg  [2:0] cnt_reg;           // key bytes matched so far
	reg  [2:0] cnt_next;          // count after this write
	reg  [7:0] exp_byte;          // byte that continues the sequence
	wire       hit;               // written byte continues the sequence
	wire       last;              // all but the final byte matched

	// continuation test and end of sequence
	assign hit  = key_wr && (wb == exp_byte);
	assign last = (cnt_reg == (`MSCB_KEY_LEN - 3'h1));
	assign done = hit && last;

	// expected byte, the key is sent from its top byte down
	always @* begin
		case (cnt_reg)
		3'h0:    exp_byte = KEY[39:32];
		3'h1:    exp_byte = KEY[31:24];
		3'h2:    exp_byte = KEY[23:16];
		3'h3:    exp_byte = KEY[15:8];
		default: exp_byte = KEY[7:0];
		endcase
	end

	// a wrong byte restarts the match; one equal to the opening byte
	// counts as byte one so that a repeated opening is not lost
	always @* begin
		cnt_next = cnt_reg;
		if (done) begin
			cnt_next = 3'h0;
		end else if (hit) begin
			cnt_next = cnt_reg + 3'h1;
		end else if (key_wr && (wb == KEY[39:32])) begin
			cnt_next = 3'h1;
		end else if (key_wr) begin
			cnt_next = 3'h0;
		end
	end

	// matched count
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			cnt_reg <= 3'h0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

endmodule
`default_nettype wire

// >>> mscb_config_bank_chk.sv
// mscb_config_bank_chk.sv: apb timing and jump pulse checks for the bank
// assumes: bound to mscb_config_bank, one clock, sync low reset
`timescale 1ns/1ps
`default_nettype none
`include "mscb_defines.vh"
module mscb_config_bank_chk (
	input wire logic        clk_sys,        // clock
	input wire logic        rst_b,          // reset
	input wire logic        psel,           // select
	input wire logic        penable,        // access
	input wire logic        pwrite,         // direction
	input wire logic [11:0] paddr,          // address
	input wire logic [31:0] pwdata,         // write data
	input wire logic [31:0] prdata,         // read data
	input wire logic        pready,         // ready
	input wire logic        pslverr,        // error
	input wire logic [2:0]  brownout_level, // trip level
	input wire logic [2:0]  spi_route,      // pin group
	input wire logic        jump_main,      // main jump
	input wire logic        jump_boot       // boot jump
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	localparam logic [11:0] KEY_A = {2'b00, `MSCB_IDX_JUMP_KEY, 2'b00};
	// first access cycle of a transfer
	wire take = psel && penable && !pready;
	wire kw = take && pwrite && paddr == KEY_A;
	////////////////////////////////////////////////////////////////////
	ready_wait_a: assert property (take |=> pready)
		else $error("ready not one cycle after access");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held too long");
	ready_cause_a: assert property (pready |-> $past(take))
		else $error("ready without access");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error outside ready");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	rdata_byte_a: assert property (prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	main_jump_a: assert property (jump_main |-> pready &&
		$past(kw && pwdata[7:0] == 8'hAA)) else $error("bad main jump");
	boot_jump_a: assert property (jump_boot |-> pready &&
		$past(kw && pwdata[7:0] == 8'h65)) else $error("bad boot jump");
	spi_onehot_a: assert property ($onehot(spi_route))
		else $error("pin group not onehot");
	level_range_a: assert property (brownout_level <= 3'h4)
		else $error("trip level out of range");
	// main scenarios reached
	cover property (jump_main);
	cover property (jump_boot);
	cover property (pready && pslverr);
endmodule
bind mscb_config_bank mscb_config_bank_chk u_chk (.clk_sys, .rst_b,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.brownout_level, .spi_route, .jump_main, .jump_boot);
`default_nettype wire

// >>> mscb_config_bank_test.sv
// mscb_config_bank_test.sv: self-checking bench for the bank
// assumes: apb slave with one wait state, settings lag one cycle
`timescale 1ns/1ps
`default_nettype none
`include "mscb_defines.vh"
module mscb_config_bank_test;
	logic        clk_sys, rst_b, psel, penable, pwrite, ev, jm, jb;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [15:0] code_offset_in;
	logic [7:0]  rdv;
	wire  [31:0] prdata;
	wire         pready, pslverr, xtal_fast, brownout_delay2;
	wire         serial_rate_wide, spi_rx_internal, jump_main, jump_boot;
	wire  [4:0]  pwm_a_invert, pwm_b_invert;
	wire  [1:0]  low_voltage_detector_delay;
	wire  [2:0]  brownout_level, spi_route;
	int          err_count = 0, comparisons = 0, cyc = 0;
	// all settings outputs in one word
	wire  [21:0] outs = {pwm_a_invert, pwm_b_invert, xtal_fast,
		low_voltage_detector_delay, brownout_delay2, brownout_level,
		serial_rate_wide, spi_route, spi_rx_internal};
	mscb_config_bank u_mscb_config_bank (.clk_sys, .rst_b, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .code_offset_in,
		.pwm_a_invert, .pwm_b_invert, .xtal_fast, .low_voltage_detector_delay,
		.brownout_delay2, .brownout_level, .serial_rate_wide, .spi_route,
		.spi_rx_internal, .jump_main, .jump_boot);
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////////////
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	// one apb transfer, held until ready is sampled high
	task automatic apb(logic w, logic [7:0] ix, logic [7:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, ix, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		{rdv, ev, jm, jb} = {prdata[7:0], pslverr, jump_main, jump_boot};
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic settle;
		repeat (2) @(posedge clk_sys);
	endtask
	task stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	// reset values, then every writable bit set and read back
	task automatic t_fld;
		logic [7:0] ix [8] = '{8'h60, 8'h61, 8'h63, 8'h65, 8'h66, 8'h67,
			8'h68, 8'h69};
		logic [7:0] mk [8] = '{8'h1F, 8'h1F, 8'h01, 8'h03, 8'h0F, 8'h01,
			8'h03, 8'h01};
		chk("reset outs", 22'h000008, outs);
		for (int i = 0; i < 13; i++) begin
			apb(1'b0, 8'h60 + i[7:0], 8'h00);
			chk("reset read", 8'h00, rdv);
		end
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, ix[i], mk[i]);
			apb(1'b0, ix[i], 8'h00);
			chk("readback", mk[i], rdv);
		end
		settle();
		chk("all set", {10'h3FF, 3'h7, 1'b1, 3'h4,
			1'b1, 3'h4, 1'b1}, outs);
		apb(1'b1, 8'h60, 8'h15);
		apb(1'b1, 8'h61, 8'h0A);
		apb(1'b1, 8'h63, 8'h00);
		settle();
		chk("polarity", {5'h15, 5'h0A, 1'b0},
			outs[21:11]);
	endtask
	// every threshold code with the delay bit toggled
	task automatic t_bor;
		logic [2:0] lv;
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, 8'h66, {4'h0, i[0], i[2:0]});
			lv = i < 2 ? `MSCB_BOR_2V3 : i == 2 ? `MSCB_BOR_2V8 :
				i == 3 ? `MSCB_BOR_3V3 : i == 4 ? `MSCB_BOR_3V7 : `MSCB_BOR_4V2;
			settle();
			chk("brownout", {i[0], lv},
				{brownout_delay2, brownout_level});
		end
	endtask
	// pin group and detector delay codes
	task automatic t_spi;
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 8'h68, i[7:0]);
			apb(1'b1, 8'h65, i[7:0]);
			settle();
			chk("route", i == 1 ? 3'h1 : i == 2 ? 3'h2 : 3'h4, spi_route);
			chk("lvd", i[1:0], low_voltage_detector_delay);
		end
	endtask
	// index outside the bank refused, offset follows its source
	task automatic t_bad;
		apb(1'b1, 8'h70, 8'h00);
		chk("err write", 1'b1, ev);
		apb(1'b0, 8'h62, 8'h00);
		chk("err read", 9'h100, {ev, rdv});
		code_offset_in <= 16'hA5C3;
		apb(1'b0, 8'h6B, 8'h00);
		chk("ofs low", 8'hC3, rdv);
		apb(1'b0, 8'h6C, 8'h00);
		chk("ofs high", 8'hA5, rdv);
	endtask
	// both keys, each broken once before completing
	task automatic t_key;
		logic [7:0] s [16] = '{8'hFF, 8'h00, 8'hFF, 8'h00, 8'h88, 8'h55,
			8'hAA, 8'h37, 8'hC8, 8'h42, 8'h00, 8'h37, 8'hC8, 8'h42, 8'h9A, 8'h65};
		for (int i = 0; i < 16; i++) begin
			apb(1'b1, 8'h6A, s[i]);
			chk("jump", {i == 6, i == 15}, {jm, jb});
		end
		apb(1'b0, 8'h6A, 8'h00);
		chk("key read", 8'h65, rdv);
	endtask
	// hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			stop_test();
		end
	end
	initial begin
		{rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
		code_offset_in = 16'h0000;
		repeat (4) @(posedge clk_sys);
		rst_b <= 1'b1;
		t_fld();
		t_bor();
		t_spi();
		t_bad();
		t_key();
		stop_test();
	end
endmodule
`default_nettype wire
